// File: hdl/dcp_defines.svh
// constants of the debug command port
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH
`define DCP_CMD_REV 8'h00
`define DCP_CMD_CNTW 8'h01
`define DCP_CMD_STAT 8'h02
`define DCP_CMD_CNTR 8'h03
`define DCP_CMD_REGRD 8'h09
`define DCP_CMD_PMWR 8'h0A
`define DCP_CMD_PMRD 8'h0B
`define DCP_CMD_CRC 8'h0E
`define DCP_ARGS_NONE 3'h0
`define DCP_ARGS_ONE 3'h1
`define DCP_ARGS_CNTW 3'h2
`define DCP_ARGS_REGRD 3'h3
`define DCP_ARGS_PM 3'h4
`define DCP_FILL 8'hFF
`define DCP_PERIPH_NIB 4'hF
`define DCP_ZERO_SIZE8 8'h00
`define DCP_ZERO_SIZE16 16'h0000
`define DCP_SIZE_REG_MAX 17'h00100
`define DCP_SIZE_PM_MAX 17'h10000
`define DCP_CNT_ONE 17'h00001
`define DCP_CNT_TWO 17'h00002
`define DCP_CTR_ZERO 16'h0000
`define DCP_CTR_ONE 16'h0001
`define DCP_ADDR_ZERO 16'h0000
`define DCP_CRC_POLY 16'h1021
`define DCP_CRC_INIT 16'hFFFF
`endif

// File: hdl/dcp_pkg.sv
// types shared by the debug command port
package dcp_pkg;
  typedef enum logic [6:0] {
    DCP_ST_IDLE = 7'h01,
    DCP_ST_ARG = 7'h02,
    DCP_ST_FETCH = 7'h04,
    DCP_ST_WAIT = 7'h08,
    DCP_ST_LOAD = 7'h10,
    DCP_ST_PUSH = 7'h20,
    DCP_ST_WR = 7'h40
  } dcp_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dcp_pm_req_t;

  typedef struct packed {
    logic rd;
    logic side_effect;
    logic [11:0] addr;
  } dcp_reg_req_t;
endpackage : dcp_pkg

// File: hdl/dcp_debug_command_port.sv
// debug command interpreter behind the debug line
`timescale 1ns/1ps
`include "dcp_defines.svh"

module dcp_debug_command_port #(
  parameter logic [15:0] REVISION = 16'h0100, // value is arbitrary
  parameter logic [11:0] WDT_STAT_ADDR = 12'hFF0, // value is arbitrary
  parameter logic [16:0] CRC_BYTES = 17'h10000,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic debug_mode,
  input wire logic read_protect,
  input wire logic flash_unlocked,
  input wire logic count_enable,
  input wire logic [7:0] debug_status,
  output logic [15:0] debug_counter,
  output logic break_request,
  output dcp_pkg::dcp_reg_req_t reg_req,
  input wire logic [7:0] reg_rd_data,
  output dcp_pkg::dcp_pm_req_t pm_req,
  input wire logic [7:0] pm_rd_data
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  dcp_pkg::dcp_state_t state_ff;
  logic [7:0] cmd_ff;
  logic [2:0] args_ff;
  logic [23:0] opnd_ff;
  logic [15:0] addr_ff;
  logic [16:0] cnt_ff;
  logic [7:0] byte_ff;
  logic [15:0] crc_ff;
  logic crc_run_ff;
  logic ok_ff;
  logic [15:0] counter_ff;
  logic brk_ff;
  dcp_pkg::dcp_pm_req_t pm_req_ff;
  dcp_pkg::dcp_reg_req_t reg_req_ff;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] buf_cnt_ff;

  logic take;
  logic last_arg;
  logic la_valid;
  logic [7:0] la_cmd;
  logic [31:0] op_word;
  logic [16:0] reg_size;
  logic [16:0] pm_size;
  logic cnt_load;
  logic rd_ok;
  logic wr_ok;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_push;
  logic buf_pop;
  logic push_last;

  function automatic logic [2:0] nargs(input logic [7:0] c);
    unique case (c)
      `DCP_CMD_CNTW: nargs = `DCP_ARGS_CNTW;
      `DCP_CMD_REGRD: nargs = `DCP_ARGS_REGRD;
      `DCP_CMD_PMWR, `DCP_CMD_PMRD: nargs = `DCP_ARGS_PM;
      default: nargs = `DCP_ARGS_NONE;
    endcase
  endfunction : nargs
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ `DCP_CRC_POLY) : {r[14:0], 1'b0};
    end
    crc_step = r;
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////////////
  // command decode
  assign rx_ready = (state_ff == dcp_pkg::DCP_ST_IDLE) || (state_ff == dcp_pkg::DCP_ST_ARG)
                  || (state_ff == dcp_pkg::DCP_ST_WR);
  assign take = rx_valid && rx_ready;
  assign last_arg = take && (state_ff == dcp_pkg::DCP_ST_ARG) && (args_ff == `DCP_ARGS_ONE);
  assign la_valid = last_arg || (take && (state_ff == dcp_pkg::DCP_ST_IDLE)
                                 && (nargs(rx_data) == `DCP_ARGS_NONE));
  assign la_cmd = last_arg ? cmd_ff : rx_data;
  assign op_word = {opnd_ff, rx_data};
  assign reg_size = (op_word[7:0] == `DCP_ZERO_SIZE8) ? `DCP_SIZE_REG_MAX
                  : {9'h000, op_word[7:0]};
  assign pm_size = (op_word[15:0] == `DCP_ZERO_SIZE16) ? `DCP_SIZE_PM_MAX
                 : {1'b0, op_word[15:0]};
  assign cnt_load = last_arg && (cmd_ff == `DCP_CMD_CNTW) && debug_mode;
  // read gate is judged once per byte, at the fetch
  assign rd_ok = debug_mode && (!read_protect || ((cmd_ff == `DCP_CMD_REGRD)
               && (addr_ff[11:8] == `DCP_PERIPH_NIB)));
  assign wr_ok = debug_mode && !read_protect && flash_unlocked;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= dcp_pkg::DCP_ST_IDLE;
    end else begin
      unique case (state_ff)
        dcp_pkg::DCP_ST_IDLE, dcp_pkg::DCP_ST_ARG: begin
          if (la_valid) begin
            unique case (la_cmd)
              `DCP_CMD_REV, `DCP_CMD_STAT, `DCP_CMD_CNTR, `DCP_CMD_REGRD, `DCP_CMD_PMRD,
              `DCP_CMD_CRC: state_ff <= dcp_pkg::DCP_ST_FETCH;
              `DCP_CMD_PMWR: state_ff <= dcp_pkg::DCP_ST_WR;
              default: state_ff <= dcp_pkg::DCP_ST_IDLE;
            endcase
          end else if (take) begin
            state_ff <= dcp_pkg::DCP_ST_ARG;
          end
        end
        dcp_pkg::DCP_ST_FETCH: state_ff <= dcp_pkg::DCP_ST_WAIT;
        dcp_pkg::DCP_ST_WAIT: state_ff <= dcp_pkg::DCP_ST_LOAD;
        dcp_pkg::DCP_ST_LOAD: begin
          state_ff <= crc_run_ff ? dcp_pkg::DCP_ST_FETCH : dcp_pkg::DCP_ST_PUSH;
        end
        dcp_pkg::DCP_ST_PUSH: begin
          if (buf_in_ready) begin
            state_ff <= push_last ? dcp_pkg::DCP_ST_IDLE : dcp_pkg::DCP_ST_FETCH;
          end
        end
        dcp_pkg::DCP_ST_WR: begin
          if (take && (cnt_ff == `DCP_CNT_ONE)) begin
            state_ff <= dcp_pkg::DCP_ST_IDLE;
          end
        end
        default: state_ff <= dcp_pkg::DCP_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operands, address and byte count
  assign push_last = cnt_ff == `DCP_CNT_ONE;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_ff <= `DCP_CMD_REV;
      args_ff <= `DCP_ARGS_NONE;
      opnd_ff <= '0;
      addr_ff <= `DCP_ADDR_ZERO;
      cnt_ff <= `DCP_CNT_ONE;
    end else begin
      if (take && (state_ff == dcp_pkg::DCP_ST_IDLE)) begin
        cmd_ff <= rx_data;
        args_ff <= nargs(rx_data);
      end else if (take && (state_ff == dcp_pkg::DCP_ST_ARG)) begin
        args_ff <= args_ff - `DCP_ARGS_ONE;
        opnd_ff <= op_word[23:0];
      end
      if (la_valid) begin
        unique case (la_cmd)
          `DCP_CMD_REV, `DCP_CMD_CNTR: cnt_ff <= `DCP_CNT_TWO;
          `DCP_CMD_STAT: cnt_ff <= `DCP_CNT_ONE;
          `DCP_CMD_CRC: begin
            cnt_ff <= CRC_BYTES;
            addr_ff <= `DCP_ADDR_ZERO;
          end
          `DCP_CMD_REGRD: begin
            cnt_ff <= reg_size;
            addr_ff <= {4'h0, op_word[19:8]};
          end
          `DCP_CMD_PMWR, `DCP_CMD_PMRD: begin
            cnt_ff <= pm_size;
            addr_ff <= op_word[31:16];
          end
          default: cnt_ff <= cnt_ff;
        endcase
      end else if ((state_ff == dcp_pkg::DCP_ST_LOAD) && crc_run_ff) begin
        addr_ff <= addr_ff + 16'h0001;
        cnt_ff <= push_last ? `DCP_CNT_TWO : (cnt_ff - `DCP_CNT_ONE);
      end else if (((state_ff == dcp_pkg::DCP_ST_PUSH) && buf_in_ready)
                   || ((state_ff == dcp_pkg::DCP_ST_WR) && take)) begin
        addr_ff <= addr_ff + 16'h0001;
        cnt_ff <= cnt_ff - `DCP_CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // memory requests
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pm_req_ff <= '0;
      reg_req_ff <= '0;
      ok_ff <= 1'b0;
    end else begin
      pm_req_ff.rd <= 1'b0;
      pm_req_ff.wr <= 1'b0;
      reg_req_ff.rd <= 1'b0;
      if (state_ff == dcp_pkg::DCP_ST_FETCH) begin
        ok_ff <= rd_ok;
        pm_req_ff.addr <= addr_ff;
        // protected reads are not issued, except the checksum's program reads and register reads in peripheral space, so nothing behind them is disturbed
        pm_req_ff.rd <= crc_run_ff || ((cmd_ff == `DCP_CMD_PMRD) && rd_ok);
        reg_req_ff.rd <= (cmd_ff == `DCP_CMD_REGRD) && rd_ok;
        reg_req_ff.addr <= addr_ff[11:0];
        reg_req_ff.side_effect <= addr_ff[11:0] == WDT_STAT_ADDR;
      end else if ((state_ff == dcp_pkg::DCP_ST_WR) && take) begin
        pm_req_ff.wr <= wr_ok;
        pm_req_ff.addr <= addr_ff;
        pm_req_ff.wdata <= rx_data;
      end
    end
  end

  assign pm_req = pm_req_ff;
  assign reg_req = reg_req_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // answer byte and program checksum
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_ff <= `DCP_FILL;
      crc_ff <= `DCP_CRC_INIT;
      crc_run_ff <= 1'b0;
    end else begin
      if (la_valid && (la_cmd == `DCP_CMD_CRC)) begin
        crc_ff <= `DCP_CRC_INIT;
        crc_run_ff <= 1'b1;
      end else if ((state_ff == dcp_pkg::DCP_ST_LOAD) && crc_run_ff) begin
        crc_ff <= crc_step(crc_ff, pm_rd_data);
        crc_run_ff <= !push_last;
      end else if (state_ff == dcp_pkg::DCP_ST_LOAD) begin
        unique case (cmd_ff)
          `DCP_CMD_REV: byte_ff <= (cnt_ff == `DCP_CNT_TWO) ? REVISION[15:8]
                                 : REVISION[7:0];
          `DCP_CMD_CNTR: byte_ff <= (cnt_ff == `DCP_CNT_TWO) ? counter_ff[15:8]
                                  : counter_ff[7:0];
          `DCP_CMD_STAT: byte_ff <= debug_status;
          `DCP_CMD_REGRD: byte_ff <= ok_ff ? reg_rd_data : `DCP_FILL;
          `DCP_CMD_PMRD: byte_ff <= ok_ff ? pm_rd_data : `DCP_FILL;
          `DCP_CMD_CRC: byte_ff <= (cnt_ff == `DCP_CNT_TWO) ? crc_ff[15:8] : crc_ff[7:0];
          default: byte_ff <= `DCP_FILL;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // debug counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      counter_ff <= `DCP_CTR_ZERO;
      brk_ff <= 1'b0;
    end else begin
      brk_ff <= !cnt_load && count_enable && (counter_ff == `DCP_CTR_ONE);
      if (cnt_load) begin
        counter_ff <= op_word[15:0];
      end else if (count_enable && (counter_ff != `DCP_CTR_ZERO)) begin
        counter_ff <= counter_ff - `DCP_CTR_ONE;
      end
    end
  end

  assign debug_counter = counter_ff;
  assign break_request = brk_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // answer buffer: a stalled receiver holds the sequencer in its push state
  assign buf_in_valid = state_ff == dcp_pkg::DCP_ST_PUSH;
  assign buf_in_ready = buf_cnt_ff != CW'(BUF_DEPTH);
  assign buf_push = buf_in_valid && buf_in_ready;
  assign tx_valid = buf_cnt_ff != '0;
  assign buf_pop = tx_valid && tx_ready;
  assign tx_data = buf_mem[rp_ff];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      buf_cnt_ff <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= `DCP_FILL;
      end
    end else begin
      if (buf_push) begin
        buf_mem[wp_ff] <= byte_ff;
        wp_ff <= (wp_ff == PW'(BUF_DEPTH - 1)) ? '0 : wp_ff + PW'(1);
      end
      if (buf_pop) begin
        rp_ff <= (rp_ff == PW'(BUF_DEPTH - 1)) ? '0 : rp_ff + PW'(1);
      end
      buf_cnt_ff <= buf_cnt_ff + CW'(buf_push) - CW'(buf_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_crc_launch;
    la_valid && (la_cmd == `DCP_CMD_CRC);
  endsequence
  sequence s_reg_zero;
    la_valid && (la_cmd == `DCP_CMD_REGRD) && (op_word[7:0] == `DCP_ZERO_SIZE8);
  endsequence

  AST_REV_HIGH: assert property (buf_push && (cmd_ff == `DCP_CMD_REV)
    && (cnt_ff == `DCP_CNT_TWO) |-> byte_ff == REVISION[15:8])
    else $error("revision high byte wrong");
  AST_CNT_LOAD: assert property (cnt_load |=> counter_ff == $past(op_word[15:0]))
    else $error("counter not loaded");
  AST_CNT_DROP: assert property (last_arg && (cmd_ff == `DCP_CMD_CNTW) && !debug_mode
    && !count_enable |=> $stable(counter_ff))
    else $error("counter changed outside debug mode");
  AST_BRK: assert property (count_enable && !cnt_load && (counter_ff == `DCP_CTR_ONE)
    |=> break_request && (counter_ff == `DCP_CTR_ZERO))
    else $error("break not raised at zero");
  AST_REG_SIZE: assert property (s_reg_zero |=> cnt_ff == `DCP_SIZE_REG_MAX)
    else $error("size zero not 256");
  AST_REG_FILL: assert property (buf_push && (cmd_ff == `DCP_CMD_REGRD) && !ok_ff
    |-> byte_ff == `DCP_FILL)
    else $error("blocked register read not FFH");
  AST_PERIPH: assert property (reg_req_ff.rd && $past(read_protect)
    |-> reg_req_ff.addr[11:8] == `DCP_PERIPH_NIB)
    else $error("protected read outside peripheral space");
  AST_SIDE: assert property (reg_req_ff.rd
    |-> (reg_req_ff.addr == $past(addr_ff[11:0]))
    && (reg_req_ff.side_effect == ($past(addr_ff[11:0]) == WDT_STAT_ADDR)))
    else $error("side effect flag wrong");
  AST_WR_GATE: assert property (pm_req_ff.wr
    |-> $past(flash_unlocked && debug_mode && !read_protect))
    else $error("program write not gated");
  AST_PM_FILL: assert property (buf_push && (cmd_ff == `DCP_CMD_PMRD) && !ok_ff
    |-> byte_ff == `DCP_FILL)
    else $error("blocked program read not FFH");
  AST_CRC_RUN: assert property (s_crc_launch |=> ##1 pm_req_ff.rd)
    else $error("checksum did not start");
  AST_NOP: assert property (la_valid && (la_cmd > `DCP_CMD_CRC)
    |=> (state_ff == dcp_pkg::DCP_ST_IDLE) && !buf_push && !pm_req_ff.wr)
    else $error("reserved code acted");

endmodule : dcp_debug_command_port

// File: bench/dcp_host_model.sv
// host side of the debug line: sends command bytes, collects answers
`timescale 1ns/1ps
module dcp_host_model (
  input wire logic clk,
  input wire logic stall,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  int timeouts;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    timeouts = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // byte is held until the edge that finds rx_ready high
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rx_valid <= 1'b1;
    rx_data <= b;
    @(negedge clk);
    while (rx_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) timeouts++;
    @(posedge clk);
  endtask : send
  // a released line shows no stale byte
  task automatic release_line();
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask : release_line
  ////////////////////////////////////////////////////////////////////////////
  // stall toggles ready so the two-entry answer buffer is drained only every other cycle
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    tx_ready <= stall ? ~tx_ready : 1'b1;
  end
endmodule : dcp_host_model

// File: bench/dcp_debug_command_port_test.sv
// self-checking bench of the debug command port
`timescale 1ns/1ps
module dcp_debug_command_port_test;
  localparam logic [15:0] REV = 16'h0100; // value is arbitrary
  localparam logic [11:0] WDT = 12'hFF0; // value is arbitrary
  localparam logic [16:0] NCRC = 17'h00010; // short crc span for sim
  typedef logic [7:0] dcp_bq_t[$];
  logic clk = 1'b0;
  logic resetn, stall, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data, debug_status, reg_rd_data, pm_rd_data;
  logic debug_mode, read_protect, flash_unlocked, count_enable, break_request;
  logic [15:0] debug_counter;
  dcp_pkg::dcp_reg_req_t reg_req;
  dcp_pkg::dcp_pm_req_t pm_req;
  int err_count, cmp_count, wdt_hits, other_fx, brk_hits;
  logic [23:0] wlog[$];
  always #2 clk = ~clk;
  dcp_host_model h (.clk(clk), .stall(stall), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  dcp_debug_command_port #(.REVISION(REV), .WDT_STAT_ADDR(WDT), .CRC_BYTES(NCRC),
    .BUF_DEPTH(2)) dut (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .debug_mode(debug_mode), .read_protect(read_protect),
    .flash_unlocked(flash_unlocked), .count_enable(count_enable),
    .debug_status(debug_status), .debug_counter(debug_counter),
    .break_request(break_request), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .pm_req(pm_req), .pm_rd_data(pm_rd_data));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pmv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : pmv
  // memory stand-ins answer the cycle after the strobe
  always @(posedge clk) begin
    if (reg_req.rd === 1'b1) begin
      reg_rd_data <= reg_req.addr[7:0] ^ 8'hA5;
      if (reg_req.side_effect === 1'b1 && reg_req.addr === WDT) wdt_hits++;
      if (reg_req.side_effect !== 1'b0 && reg_req.addr !== WDT) other_fx++;
    end
    if (pm_req.rd === 1'b1) pm_rd_data <= pmv(pm_req.addr);
    if (pm_req.wr === 1'b1) wlog.push_back({pm_req.addr, pm_req.wdata});
    if (break_request === 1'b1) brk_hits++;
  end
  function automatic dcp_bq_t reg_exp(input logic [11:0] a, input int n,
    input logic prot, input logic dm);
    dcp_bq_t q;
    logic [11:0] x;
    for (int i = 0; i < n; i++) begin
      x = a + 12'(i);
      q.push_back((!dm || (prot && x[11:8] != 4'hF)) ? 8'hFF : x[7:0] ^ 8'hA5);
    end
    return q;
  endfunction : reg_exp
  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    c = 16'hFFFF;
    for (int a = 0; a < int'(NCRC); a++) begin
      c = c ^ {pmv(16'(a)), 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction : crc_exp
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    err_count += h.timeouts;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_bytes(input dcp_bq_t exp, input string what);
    int n;
    n = 0;
    while (h.got.size() < exp.size() && n < 3000 + 8 * exp.size()) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000 + 8 * exp.size()) begin
      err_count++;
      $display("MISMATCH %0t %s timed out", $time, what);
      conclude();
    end else begin
      repeat (12) @(posedge clk);
      chk(24'(h.got.size()), 24'(exp.size()), what);
      for (int i = 0; i < exp.size() && i < h.got.size(); i++) chk(h.got[i], exp[i], what);
      h.got.delete();
    end
  endtask : chk_bytes
  task automatic put(input dcp_bq_t bs);
    foreach (bs[i]) h.send(bs[i]);
    h.release_line();
  endtask : put
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_rev();
    stall <= 1'b1;
    put({8'h00});
    chk_bytes({REV[15:8], REV[7:0]}, "revision");
    stall <= 1'b0;
    $display("test revision done");
  endtask : t_rev
  task automatic t_stat();
    debug_status <= 8'hA5;
    put({8'h02});
    chk_bytes({8'hA5}, "status");
    $display("test status done");
  endtask : t_stat
  task automatic t_count();
    debug_mode <= 1'b1;
    put({8'h01, 8'h12, 8'h34});
    repeat (2) @(posedge clk);
    chk(debug_counter, 16'h1234, "counter load");
    put({8'h03});
    chk_bytes({8'h12, 8'h34}, "counter read");
    debug_mode <= 1'b0;
    put({8'h01, 8'hAB, 8'hCD});
    repeat (2) @(posedge clk);
    chk(debug_counter, 16'h1234, "counter kept");
    debug_mode <= 1'b1;
    put({8'h01, 8'h00, 8'h03});
    repeat (2) @(posedge clk);
    count_enable <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(debug_counter, 16'h0001, "count down");
    @(posedge clk);
    @(negedge clk);
    chk(debug_counter, 16'h0000, "count zero");
    repeat (4) @(posedge clk);
    chk(brk_hits, 1, "break");
    chk(debug_counter, 16'h0000, "stay zero");
    count_enable <= 1'b0;
    $display("test counter done");
  endtask : t_count
  task automatic t_regs();
    put({8'h09, 8'h01, 8'h20, 8'h03});
    chk_bytes(reg_exp(12'h120, 3, 1'b0, 1'b1), "reg read");
    put({8'h09, 8'h02, 8'h00, 8'h00});
    chk_bytes(reg_exp(12'h200, 256, 1'b0, 1'b1), "reg size zero");
    put({8'h09, 8'(WDT[11:8]), WDT[7:0], 8'h01});
    chk_bytes(reg_exp(WDT, 1, 1'b0, 1'b1), "wdt read");
    chk(wdt_hits, 1, "wdt effect");
    chk(other_fx, 0, "no side effect");
    read_protect <= 1'b1;
    put({8'h09, 8'h0E, 8'hFF, 8'h03});
    chk_bytes(reg_exp(12'hEFF, 3, 1'b1, 1'b1), "protected read");
    read_protect <= 1'b0;
    debug_mode <= 1'b0;
    put({8'h09, 8'h0F, 8'h00, 8'h02});
    chk_bytes(reg_exp(12'hF00, 2, 1'b0, 1'b0), "reg no debug");
    debug_mode <= 1'b1;
    $display("test register read done");
  endtask : t_regs
  task automatic wr_case(input logic fu, input logic rp, input logic dm);
    flash_unlocked <= fu;
    read_protect <= rp;
    debug_mode <= dm;
    wlog.delete();
    put({8'h0A, 8'h00, 8'h10, 8'h00, 8'h02, 8'hC3, 8'h5A});
    repeat (4) @(posedge clk);
  endtask : wr_case
  task automatic t_prog();
    wr_case(1'b1, 1'b0, 1'b1);
    chk(wlog.size(), 2, "write count");
    if (wlog.size() == 2) chk(wlog[0], 24'h0010C3, "write 0");
    if (wlog.size() == 2) chk(wlog[1], 24'h00115A, "write 1");
    wr_case(1'b0, 1'b0, 1'b1);
    chk(wlog.size(), 0, "locked write");
    wr_case(1'b1, 1'b1, 1'b1);
    chk(wlog.size(), 0, "protected write");
    wr_case(1'b1, 1'b0, 1'b0);
    chk(wlog.size(), 0, "write no debug");
    debug_mode <= 1'b1;
    put({8'h0B, 8'h12, 8'hFF, 8'h00, 8'h02});
    chk_bytes({pmv(16'h12FF), pmv(16'h1300)}, "prog read");
    read_protect <= 1'b1;
    put({8'h0B, 8'h12, 8'hFF, 8'h00, 8'h02});
    chk_bytes({8'hFF, 8'hFF}, "prog protected");
    read_protect <= 1'b0;
    debug_mode <= 1'b0;
    put({8'h0B, 8'h12, 8'hFF, 8'h00, 8'h01});
    chk_bytes({8'hFF}, "prog no debug");
    debug_mode <= 1'b1;
    $display("test program memory done");
  endtask : t_prog
  task automatic t_crc();
    logic [15:0] c;
    c = crc_exp();
    read_protect <= 1'b1;
    put({8'h0E});
    chk_bytes({c[15:8], c[7:0]}, "crc");
    read_protect <= 1'b0;
    $display("test crc done");
  endtask : t_crc
  // reserved codes must not swallow the status command behind them
  task automatic t_nop();
    wlog.delete();
    debug_status <= 8'h3C;
    put({8'h0F, 8'h13, 8'h80, 8'hFF, 8'h02});
    chk_bytes({8'h3C}, "reserved");
    chk(debug_counter, 16'h0000, "reserved state");
    chk(wlog.size(), 0, "reserved write");
    $display("test reserved done");
  endtask : t_nop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    stall = 1'b0;
    debug_mode = 1'b0;
    read_protect = 1'b0;
    flash_unlocked = 1'b0;
    count_enable = 1'b0;
    debug_status = 8'h00;
    reg_rd_data = 8'h00;
    pm_rd_data = 8'h00;
    err_count = 0;
    cmp_count = 0;
    wdt_hits = 0;
    other_fx = 0;
    brk_hits = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_rev();
    t_stat();
    t_count();
    t_regs();
    t_prog();
    t_crc();
    t_nop();
    conclude();
  end
endmodule : dcp_debug_command_port_test
